/* hw/vpif_pkg.sv */
// package: register map, field positions and types for the video port interrupt flags
package vpif_pkg;
	localparam int unsigned VPIF_AW = 4;
	localparam logic [VPIF_AW-1:0] VPIF_OFF_ENABLE = 4'h0;
	localparam logic [VPIF_AW-1:0] VPIF_OFF_STATUS = 4'h4;
	localparam logic [VPIF_AW-1:0] VPIF_OFF_LFB_CTRL = 4'h8;
	localparam logic [31:0] VPIF_ENABLE_RESET = 32'h00000000;
	localparam logic [31:0] VPIF_STATUS_RESET = 32'h00000000;
	localparam logic [2:0] VPIF_CTRL_RESET = 3'h0;
	// writable bits: 23..16, 14..10, 7..0 in enable; status lacks bit 0
	localparam logic [31:0] VPIF_ENABLE_MASK = 32'h00FF7CFF;
	localparam logic [31:0] VPIF_STATUS_MASK = 32'h00FF7CFE;
	localparam int unsigned VPIF_BIT_GLOBAL = 0;
	localparam int unsigned VPIF_BIT_A_OVERRUN = 1;
	localparam int unsigned VPIF_BIT_A_DONE = 2;
	localparam int unsigned VPIF_BIT_A_SYNC = 3;
	localparam int unsigned VPIF_BIT_A_VINT1 = 4;
	localparam int unsigned VPIF_BIT_A_VINT2 = 5;
	localparam int unsigned VPIF_BIT_A_SHORT = 6;
	localparam int unsigned VPIF_BIT_A_LONG = 7;
	localparam int unsigned VPIF_BIT_STC = 10;
	localparam int unsigned VPIF_BIT_B_LONG = 23;
	localparam int unsigned VPIF_CTRL_DETECT_EN = 0;
	localparam int unsigned VPIF_CTRL_VRESET = 1;
	localparam int unsigned VPIF_CTRL_MODE_LSB = 2;
	localparam int unsigned VPIF_LINE_W = 12;

	typedef enum logic [3:0] {
		VPIF_MODE_BT656 = 4'h1,
		VPIF_MODE_YC = 4'h2,
		VPIF_MODE_RAW = 4'h4,
		VPIF_MODE_TSI = 4'h8
	} vpif_mode_e;

	typedef struct packed {
		logic [VPIF_AW-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} vpif_bus_s;

	typedef struct packed {
		logic line_tick;
		logic [VPIF_LINE_W-1:0] line_count;
		logic [VPIF_LINE_W-1:0] y_stop_value;
		logic display_mode;
	} vpif_chb_s;
endpackage : vpif_pkg

/* hw/vpif_flags.sv */
// video port interrupt enable/status registers and channel B long field detection
`timescale 1ns/1ps
module vpif_flags (
	input wire logic mclk,
	input wire logic rst_n,
	input wire vpif_pkg::vpif_bus_s bus,
	output logic [31:0] rdata,
	input wire logic [31:0] event_pulse,
	input wire vpif_pkg::vpif_chb_s chb,
	output logic irq
);
	import vpif_pkg::*;

	// ============================================================
	// registers
	logic [31:0] irq_enable_reg;
	logic [31:0] irq_status_reg;
	logic [2:0] lfb_ctrl_reg;
	logic [31:0] rdata_reg;
	logic [31:0] set_vec;
	logic [31:0] clr_vec;
	logic chan_b_long_field;
	logic lf_armed_reg;
	logic long_mode;
	vpif_mode_e mode;

	// ============================================================
	// register writes
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_enable_reg <= VPIF_ENABLE_RESET;
		end else if (bus.wr && bus.addr == VPIF_OFF_ENABLE) begin
			irq_enable_reg <= bus.wdata & VPIF_ENABLE_MASK;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lfb_ctrl_reg <= VPIF_CTRL_RESET;
		end else if (bus.wr && bus.addr == VPIF_OFF_LFB_CTRL) begin
			lfb_ctrl_reg <= bus.wdata[2:0];
		end
	end

	// ============================================================
	// channel B long field detection
	always_comb begin
		case (lfb_ctrl_reg[VPIF_CTRL_MODE_LSB])
			1'b0: mode = VPIF_MODE_BT656;
			default: mode = VPIF_MODE_RAW;
		endcase
	end

	// only bt656/yc capture with detection on; raw, transport stream, display never
	assign long_mode = (mode == VPIF_MODE_BT656 || mode == VPIF_MODE_YC)
		&& !chb.display_mode && lfb_ctrl_reg[VPIF_CTRL_DETECT_EN];

	// arm once per field so a long field flags once until the counter resets
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lf_armed_reg <= 1'b1;
		end else if (chb.line_tick && chb.line_count == '0) begin
			lf_armed_reg <= 1'b1;
		end else if (chan_b_long_field) begin
			lf_armed_reg <= 1'b0;
		end
	end

	always_comb begin
		chan_b_long_field = 1'b0;
		if (long_mode && chb.line_tick && lf_armed_reg) begin
			if (lfb_ctrl_reg[VPIF_CTRL_VRESET]) begin
				chan_b_long_field = 1'b1;
			end else if (chb.line_count == chb.y_stop_value + 1'b1) begin
				chan_b_long_field = 1'b1;
			end
		end
	end

	// ============================================================
	// status flags
	always_comb begin
		set_vec = event_pulse;
		set_vec[VPIF_BIT_B_LONG] = chan_b_long_field;
		set_vec = set_vec & VPIF_STATUS_MASK;
		clr_vec = '0;
		if (bus.wr && bus.addr == VPIF_OFF_STATUS) begin
			clr_vec = bus.wdata & VPIF_STATUS_MASK;
		end
	end

	// set wins over a same-cycle clear; events recorded regardless of enables
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_reg <= VPIF_STATUS_RESET;
		end else begin
			irq_status_reg <= (irq_status_reg & ~clr_vec) | set_vec;
		end
	end

	// ============================================================
	// read port
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= '0;
		end else if (bus.rd) begin
			if (bus.addr == VPIF_OFF_ENABLE) begin
				rdata_reg <= irq_enable_reg;
			end else if (bus.addr == VPIF_OFF_STATUS) begin
				rdata_reg <= irq_status_reg;
			end else if (bus.addr == VPIF_OFF_LFB_CTRL) begin
				rdata_reg <= {29'h0, lfb_ctrl_reg};
			end else begin
				rdata_reg <= '0;
			end
		end else begin
			rdata_reg <= '0;
		end
	end
	assign rdata = rdata_reg;

	// ============================================================
	// interrupt output
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_enable_reg[VPIF_BIT_GLOBAL]
				&& |(irq_status_reg & irq_enable_reg & VPIF_STATUS_MASK);
		end
	end
endmodule : vpif_flags

/* testbench/vpif_flags_checker.sv */
// checker: port-level assertions for the video port interrupt flags
`timescale 1ns/1ps
module vpif_flags_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire vpif_pkg::vpif_bus_s bus,
	input wire logic [31:0] rdata,
	input wire logic [31:0] event_pulse,
	input wire logic irq
);
	import vpif_pkg::*;
	logic [31:0] en_reg;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ==========
	// shadow of the enable register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			en_reg <= 32'h0;
		else if (bus.wr && bus.addr == 4'h0)
			en_reg <= bus.wdata & VPIF_ENABLE_MASK;
	end
	// ==========
	// properties
	sequence s_pend;
		en_reg[0] && !bus.wr && |(event_pulse & en_reg & 32'h007F7CFE);
	endsequence
	property p_ev; s_pend |-> ##2 irq; endproperty
	a_ev: assert property (p_ev) else $error("irq missing");
	property p_glob; !en_reg[0] |=> !irq; endproperty
	a_glob: assert property (p_glob) else $error("irq without global");
	property p_src; en_reg[31:1] == 32'h0 |=> !irq; endproperty
	a_src: assert property (p_src) else $error("irq without source");
	property p_rose; $rose(irq) |-> $past(en_reg[0]); endproperty
	a_rose: assert property (p_rose) else $error("irq rose ungated");
	property p_rden; bus.rd && bus.addr == 4'h0 |=> rdata == $past(en_reg); endproperty
	a_rden: assert property (p_rden) else $error("enable readback");
	property p_rsv; (rdata & 32'hFF008300) == 32'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	property p_unm; bus.rd && bus.addr == 4'hC |=> rdata == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");
	property p_idle; !bus.rd |=> rdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("stray read data");
endmodule : vpif_flags_checker

/* testbench/vpif_flags_bench.sv */
// bench: register and interrupt tests for the video port interrupt flags
`timescale 1ns/1ps
module vpif_flags_bench;
	import vpif_pkg::*;
	logic mclk = 0;
	logic rst_n = 0;
	logic irq;
	logic [31:0] rdata;
	logic [31:0] event_pulse = 0;
	vpif_bus_s bus = '0;
	vpif_chb_s chb = '0;
	int n_fail = 0;
	int samples_checked = 0;
	int srcs[8] = '{1, 2, 3, 4, 5, 6, 7, 10};
	vpif_flags uut (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.event_pulse(event_pulse), .chb(chb), .irq(irq));
	initial forever #12.5 mclk = ~mclk;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk) bus.wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge mclk) bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge mclk) bus.rd <= 1'b0;
		#1 chk(rdata, e);
	endtask : rd
	task pulse(input logic [31:0] v);
		@(posedge mclk) event_pulse <= v;
		@(posedge mclk) event_pulse <= 32'h0;
	endtask : pulse
	task tick(input logic [11:0] n, input logic dm = 1'b0);
		@(posedge mclk) chb <= '{1'b1, n, 12'h00A, dm};
		@(posedge mclk) chb.line_tick <= 1'b0;
	endtask : tick
	task irq_is(input logic v);
		repeat (2) @(posedge mclk);
		#1 chk({31'h0, irq}, {31'h0, v});
	endtask : irq_is
	task test_done;
		$display("checked %0d bad %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		rd(4'h0, 32'h0);
		rd(4'h4, 32'h0);
		rd(4'hC, 32'h0);
		wr(4'h0, 32'hFFFFFFFF);
		rd(4'h0, 32'h00FF7CFF);
		wr(4'h0, 32'h00FF7CFE);
		pulse(32'hFFFFFFFF);
		irq_is(1'b0);
		rd(4'h4, 32'h007F7CFE);
		wr(4'h4, 32'h0);
		rd(4'h4, 32'h007F7CFE);
		wr(4'h4, 32'hFFFFFF7F);
		rd(4'h4, 32'h00000080);
		wr(4'h0, 32'h00000041);
		irq_is(1'b0);
		wr(4'h4, 32'h00000080);
		$display("registers done");
		foreach (srcs[i]) begin
			wr(4'h0, 32'h1 | (32'h1 << srcs[i]));
			pulse(32'h1 << srcs[i]);
			irq_is(1'b1);
			wr(4'h4, 32'h1 << srcs[i]);
			irq_is(1'b0);
		end
		$display("sources done");
		wr(4'h8, 32'h1);
		tick(12'h000);
		tick(12'h00A);
		rd(4'h4, 32'h0);
		tick(12'h00B);
		rd(4'h4, 32'h00800000);
		wr(4'h4, 32'h00800000);
		wr(4'h8, 32'h5);
		tick(12'h000);
		tick(12'h00B);
		rd(4'h4, 32'h0);
		wr(4'h8, 32'h1);
		tick(12'h000, 1'b1);
		tick(12'h00B, 1'b1);
		rd(4'h4, 32'h0);
		wr(4'h8, 32'h3);
		tick(12'h000);
		tick(12'h005);
		rd(4'h4, 32'h00800000);
		$display("long field done");
		test_done();
	end
endmodule : vpif_flags_bench
bind vpif_flags vpif_flags_checker chk_i (.mclk(mclk), .rst_n(rst_n), .bus(bus),
	.rdata(rdata), .event_pulse(event_pulse), .irq(irq));
